//--- design/vector_ramp_gen.sv
// Ramp generator end: mode decode, ramp timing, pattern and blanking.
`include "vector_ramp_params.svh"
`timescale 1ns/1ns
`default_nettype none
module vector_ramp_gen
    import vector_ramp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        converter_overflow,
    output logic             unblank,
    output logic             attenuate,
    output logic             ramp_rising,
    output logic             conic_active,
    output logic [11:0]      ramp_value,
    vector_ramp_if.generator link
);
    ////////////////////////////////////////////////////////////////////////
    // Sequencer state.
    ramp_state_type state;
    ramp_state_type next_state;
    logic           toggle;
    logic           next_toggle;
    logic [13:0]    count;
    logic [13:0]    next_count;
    logic           short_vec;
    logic           next_short;
    logic           conic_arm;
    logic           next_conic_arm;
    logic           next_conic_active;
    logic           next_ramp_rising;
    logic [11:0]    next_ramp;
    logic           lim_a_n;
    logic           next_lim_a_n;
    logic           lim_b_n;
    logic           next_lim_b_n;
    logic           start_seen;
    logic           draw_mode;
    // Code latches, pattern clock and beam gating.
    logic [1:0]     pat_code;
    logic [1:0]     next_pat_code;
    logic [1:0]     spd_code;
    logic [1:0]     next_spd_code;
    logic [3:0]     div;
    logic [3:0]     next_div;
    logic [5:0]     pat_cnt;
    logic [5:0]     next_pat_cnt;
    logic [1:0]     ovf_sync;
    logic [1:0]     next_ovf_sync;
    logic           next_unblank;
    logic           next_attenuate;
    logic           pat_tick;
    logic           pat_on;

    ////////////////////////////////////////////////////////////////////////
    // Ramp length in cycles. Short vectors get a fixed length so that the
    // beam dwell does not shrink with the displacement. Moves run four times
    // faster, and a zero length is raised to one so that every ramp ends.
    // The count is two bits wider than the displacement to hold four times it.
    function automatic logic [13:0] ramp_len(input logic [11:0] d, input logic fast);
        logic [13:0] n;
        if (d < `SHORT_LIMIT) begin
            n = 14'(`SHORT_CYCLES);
        end else begin
            n = {2'h0, d} << `LEN_SHIFT;
        end
        if (fast) begin
            n = n >> `LEN_SHIFT;
        end
        if (n == 14'h0000) begin
            n = 14'h0001;
        end
        return n;
    endfunction

    // True when the mode code calls for a drawn, unblanked vector.
    function automatic logic is_draw(input logic [1:0] mode);
        return (mode == `MODE_VECTOR) || (mode == `MODE_CONIC);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pattern clock and line structure. The slow tick comes once in sixteen
    // cycles from a free-running divider; the pattern counter only advances
    // while a vector is drawn, so every vector starts its pattern afresh.
    always_comb begin
        next_ovf_sync = {ovf_sync[0], converter_overflow};
        next_pat_code = link.pattern_code_strobe_n ? pat_code
                      : ~{link.pattern_code_bit1_n, link.pattern_code_bit0_n};
        next_spd_code = link.speed_code_strobe_n ? spd_code
                      : ~{link.speed_code_bit1_n, link.speed_code_bit0_n};
        next_div = div + 4'h1;
        if (spd_code == `SPEED_FAST) begin
            pat_tick = 1'b1;
        end else begin
            pat_tick = (div == `DIV_SLOW);
        end
        if (state == st_draw) begin
            next_pat_cnt = pat_cnt + {5'h00, pat_tick};
        end else begin
            next_pat_cnt = 6'h00;
        end
        // Centerline is a long dash, a gap, a short dash and a gap.
        unique case (pat_code)
            `PAT_SOLID:  pat_on = 1'b1;
            `PAT_DOTTED: pat_on = (pat_cnt[1:0] == 2'h0);
            `PAT_DASHED: pat_on = ~pat_cnt[4];
            `PAT_CENTER: pat_on = (pat_cnt[5:4] != 2'h3) || (pat_cnt[5:2] == 4'hd);
        endcase
        next_unblank = (state == st_draw) && !ovf_sync[1] && pat_on;
        next_attenuate = (state == st_draw) && short_vec;
    end

    // Registers of the pattern and beam gating group.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovf_sync  <= 2'h0;
            pat_code  <= `PAT_SOLID;
            spd_code  <= `SPEED_FAST;
            div       <= 4'h0;
            pat_cnt   <= 6'h00;
            unblank   <= 1'b0;
            attenuate <= 1'b0;
        end else begin
            ovf_sync  <= next_ovf_sync;
            pat_code  <= next_pat_code;
            spd_code  <= next_spd_code;
            div       <= next_div;
            pat_cnt   <= next_pat_cnt;
            unblank   <= next_unblank;
            attenuate <= next_attenuate;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer. Init clears the toggle; an accepted start inverts it and
    // begins a timed ramp. A start that arrives while the ramp is moving is
    // ignored, so only an init or a reset stops a ramp short of the other limit.
    always_comb begin
        start_seen = !link.vector_start_strobe_n;
        draw_mode = is_draw({link.mode_select_bit2, link.mode_select_bit1});
        next_state = state;
        next_toggle = toggle;
        next_count = count;
        next_short = short_vec;
        next_conic_arm = conic_arm;
        next_conic_active = conic_active;
        if (!link.vector_init_pulse_n) begin
            next_toggle = 1'b0;
            next_state = st_idle_type_v;
        end else begin
            unique case (state)
                st_idle_type_v: begin
                    if (start_seen) begin
                        next_toggle = ~toggle;
                        next_conic_active = conic_arm;
                        next_conic_arm = 1'b0;
                        next_short = draw_mode && (link.displacement < `SHORT_LIMIT);
                        next_count = ramp_len(link.displacement, !draw_mode);
                        next_state = draw_mode ? st_draw : st_move;
                    end
                end
                st_move, st_draw: begin
                    next_count = count - 14'h0001;
                    if (count == 14'h0001) begin
                        next_state = st_idle_type_v;
                    end
                end
                default: begin
                    next_state = st_idle_type_v;
                end
            endcase
        end
        // A conic start wins over a clear that falls in the same cycle.
        if (!link.conic_start_strobe_n) begin
            next_conic_arm = 1'b1;
        end
        next_ramp_rising = next_toggle;
        next_lim_a_n = !((next_state == st_idle_type_v) && next_toggle);
        next_lim_b_n = !((next_state == st_idle_type_v) && !next_toggle);
        // At rest the ramp sits at the limit that the toggle points to.
        if (state == st_idle_type_v) begin
            next_ramp = toggle ? 12'hfff : 12'h000;
        end else begin
            next_ramp = toggle ? ramp_value + 12'h001 : ramp_value - 12'h001;
        end
    end

    // Registers of the sequencer group.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state        <= st_idle_type_v;
            toggle       <= 1'b0;
            count        <= 14'h0000;
            short_vec    <= 1'b0;
            conic_arm    <= 1'b0;
            conic_active <= 1'b0;
            ramp_rising  <= 1'b0;
            ramp_value   <= 12'h000;
            lim_a_n      <= 1'b1;
            lim_b_n      <= 1'b0;
        end else begin
            state        <= next_state;
            toggle       <= next_toggle;
            count        <= next_count;
            short_vec    <= next_short;
            conic_arm    <= next_conic_arm;
            conic_active <= next_conic_active;
            ramp_rising  <= next_ramp_rising;
            ramp_value   <= next_ramp;
            lim_a_n      <= next_lim_a_n;
            lim_b_n      <= next_lim_b_n;
        end
    end

    // Limit flags leave straight from their flip-flops.
    assign link.ramp_at_limit_a_n = lim_a_n;
    assign link.ramp_at_limit_b_n = lim_b_n;
endmodule
`default_nettype wire

//--- design/vector_ramp_params.svh
// Constants for the vector ramp and conic control block.
`ifndef VECTOR_RAMP_PARAMS_SVH
`define VECTOR_RAMP_PARAMS_SVH
`define MODE_MOVE        2'h0
`define MODE_POINT       2'h1
`define MODE_VECTOR      2'h2
`define MODE_CONIC       2'h3
`define PAT_SOLID        2'h0
`define PAT_DOTTED       2'h1
`define PAT_DASHED       2'h2
`define PAT_CENTER       2'h3
`define SPEED_FAST       2'h0
`define SHORT_LIMIT      12'h080 // One thirty-second of a 4096-step screen.
`define SHORT_NS         1250
`define CLK_NS           4
`define SHORT_CYCLES     12'((`SHORT_NS + `CLK_NS - 1) / `CLK_NS)
`define DIV_SLOW         4'hf
`define FAST_DIV         4'h3
`define LEN_SHIFT        2
`endif

//--- design/vector_ramp_pkg.sv
// Types shared by both ends of the vector ramp link.
package vector_ramp_pkg;
    typedef enum logic [1:0] {
        st_idle_type_v = 2'h0,
        st_move        = 2'h1,
        st_draw        = 2'h2
    } ramp_state_type;
endpackage

//--- design/vector_ramp_if.sv
// Interface joining the graphic controller end to the ramp generator end.
`timescale 1ns/1ns
`default_nettype none
interface vector_ramp_if;
    logic        mode_select_bit1;
    logic        mode_select_bit2;
    logic        vector_start_strobe_n;
    logic        conic_start_strobe_n;
    logic        vector_init_pulse_n;
    logic        speed_code_bit0_n;
    logic        speed_code_bit1_n;
    logic        speed_code_strobe_n;
    logic        pattern_code_bit0_n;
    logic        pattern_code_bit1_n;
    logic        pattern_code_strobe_n;
    logic [11:0] displacement;
    logic        ramp_at_limit_a_n;
    logic        ramp_at_limit_b_n;
    modport controller (
        output mode_select_bit1, mode_select_bit2, vector_start_strobe_n,
               conic_start_strobe_n, vector_init_pulse_n, speed_code_bit0_n,
               speed_code_bit1_n, speed_code_strobe_n, pattern_code_bit0_n,
               pattern_code_bit1_n, pattern_code_strobe_n, displacement,
        input  ramp_at_limit_a_n, ramp_at_limit_b_n
    );
    modport generator (
        input  mode_select_bit1, mode_select_bit2, vector_start_strobe_n,
               conic_start_strobe_n, vector_init_pulse_n, speed_code_bit0_n,
               speed_code_bit1_n, speed_code_strobe_n, pattern_code_bit0_n,
               pattern_code_bit1_n, pattern_code_strobe_n, displacement,
        output ramp_at_limit_a_n, ramp_at_limit_b_n
    );
endinterface
`default_nettype wire

//--- design/vector_controller.sv
// Graphic controller end: turns user commands into link strobes.
`include "vector_ramp_params.svh"
`timescale 1ns/1ns
`default_nettype none
module vector_controller
    import vector_ramp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        cmd_init,
    input  wire logic        cmd_start,
    input  wire logic [1:0]  cmd_mode,
    input  wire logic [11:0] cmd_displacement,
    input  wire logic        cmd_speed_load,
    input  wire logic [1:0]  cmd_speed,
    input  wire logic        cmd_pattern_load,
    input  wire logic [1:0]  cmd_pattern,
    output logic             busy,
    vector_ramp_if.controller link
);
    logic       next_busy;
    logic       drv_start, next_start, drv_conic, next_conic, drv_init, next_init;
    logic       drv_spd, next_spd, drv_pat, next_pat;
    logic [1:0] mode, next_mode, spd, next_spd_code, pat, next_pat_code;
    logic [11:0] disp, next_disp;

    ////////////////////////////////////////////////////////////////////////
    // Strobe generation; conic start precedes its vector start by a cycle.
    always_comb begin
        next_start = 1'b0;
        next_conic = 1'b0;
        next_init  = cmd_init;
        next_spd   = cmd_speed_load;
        next_pat   = cmd_pattern_load;
        next_mode  = mode;
        next_disp  = disp;
        next_spd_code = cmd_speed_load ? cmd_speed : spd;
        next_pat_code = cmd_pattern_load ? cmd_pattern : pat;
        next_busy  = busy;
        if (drv_conic) begin
            next_start = 1'b1;
        end else if (cmd_start && !busy) begin
            next_mode = cmd_mode;
            next_disp = cmd_displacement;
            next_busy = 1'b1;
            if (cmd_mode == `MODE_CONIC) begin
                next_conic = 1'b1;
            end else begin
                next_start = 1'b1;
            end
        end else if (busy && !drv_start
                     && (link.ramp_at_limit_a_n != link.ramp_at_limit_b_n)) begin
            next_busy = 1'b0; // Ramp rests at a limit again.
        end
    end

    // Registers of strobes and codes; the limit flags share this clock.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
            drv_start <= 1'b0;
            drv_conic <= 1'b0;
            drv_init <= 1'b0;
            drv_spd <= 1'b0;
            drv_pat <= 1'b0;
            mode <= `MODE_MOVE;
            disp <= 12'h000;
            spd <= `SPEED_FAST;
            pat <= `PAT_SOLID;
        end else begin
            busy <= next_busy;
            drv_start <= next_start;
            drv_conic <= next_conic;
            drv_init <= next_init;
            drv_spd <= next_spd;
            drv_pat <= next_pat;
            mode <= next_mode;
            disp <= next_disp;
            spd <= next_spd_code;
            pat <= next_pat_code;
        end
    end

    // Link pins are active low where named so.
    assign link.vector_start_strobe_n = ~drv_start;
    assign link.conic_start_strobe_n  = ~drv_conic;
    assign link.vector_init_pulse_n   = ~drv_init;
    assign link.speed_code_strobe_n   = ~drv_spd;
    assign link.pattern_code_strobe_n = ~drv_pat;
    assign link.mode_select_bit1      = mode[0];
    assign link.mode_select_bit2      = mode[1];
    assign link.speed_code_bit0_n     = ~spd[0];
    assign link.speed_code_bit1_n     = ~spd[1];
    assign link.pattern_code_bit0_n   = ~pat[0];
    assign link.pattern_code_bit1_n   = ~pat[1];
    assign link.displacement          = disp;
endmodule
`default_nettype wire

//--- tb/vector_ramp_chk.sv
// Concurrent checks on the link between the controller and the ramp generator.
`timescale 1ns/1ns
`default_nettype none
module vector_ramp_chk (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        mode_select_bit2,
    input wire logic        vector_start_strobe_n,
    input wire logic        conic_start_strobe_n,
    input wire logic        vector_init_pulse_n,
    input wire logic        pattern_code_strobe_n,
    input wire logic [11:0] displacement,
    input wire logic        ramp_at_limit_a_n,
    input wire logic        ramp_at_limit_b_n
);
    logic        moving;
    logic        expect_a;
    logic        len_ok;
    logic [15:0] cnt;
    logic [15:0] exp_len;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // The ramp is moving while neither limit flag is active.
    assign moving = ramp_at_limit_a_n & ramp_at_limit_b_n;
    // Tracks the limit that the ramp should reach and the length of long draws.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            expect_a <= 1'b0;
            len_ok   <= 1'b0;
            cnt      <= 16'h0;
        end else if (!vector_init_pulse_n) begin
            expect_a <= 1'b0;
        end else if (!vector_start_strobe_n) begin
            expect_a <= !ramp_at_limit_b_n;
            len_ok   <= mode_select_bit2 && displacement >= 12'h080;
            exp_len  <= {2'h0, displacement, 2'h0};
            cnt      <= 16'h0;
        end else if (moving) begin
            cnt <= cnt + 16'h1;
        end
    end
    sequence ramp_leaves;
        ##[1:2] moving;
    endsequence
    limits_exclusive_a:
        assert property (ramp_at_limit_a_n | ramp_at_limit_b_n) else $error("both limits on");
    start_at_rest_a:
        assert property (!vector_start_strobe_n |-> !moving) else $error("start while moving");
    init_single_a:
        assert property (!vector_init_pulse_n |=> vector_init_pulse_n) else $error("long init");
    pattern_single_a:
        assert property (!pattern_code_strobe_n |=> pattern_code_strobe_n) else $error("long strobe");
    conic_order_a:
        assert property (!conic_start_strobe_n |=> !vector_start_strobe_n) else $error("conic order");
    limit_drop_a:
        assert property (!vector_start_strobe_n |-> ramp_leaves) else $error("ramp did not leave");
    short_fixed_a:
        assert property (!vector_start_strobe_n && mode_select_bit2 && displacement < 12'h080
            |-> ramp_leaves ##290 moving ##[1:40] !moving) else $error("short ramp length");
    alternate_a:
        assert property ($fell(ramp_at_limit_a_n) || $fell(ramp_at_limit_b_n)
            |-> ramp_at_limit_a_n == !expect_a) else $error("ramp did not alternate");
    long_length_a:
        assert property ($rose(!moving) && len_ok |-> cnt <= exp_len + 16'h6
            && cnt + 16'h6 >= exp_len) else $error("long ramp length");
endmodule
`default_nettype wire

//--- tb/tb_vector_ramp_conic_control.sv
// Self-checking bench for the controller and ramp generator pair.
`timescale 1ns/1ns
`default_nettype none
module tb_vector_ramp_conic_control;
    import vector_ramp_pkg::*;
    typedef struct {
        logic [1:0]  mode;
        logic [11:0] disp;
        logic [1:0]  pat;
        logic [1:0]  spd;
        logic        ovf;
        logic [3:0]  want;  // Unblank, attenuate, conic, broken pattern.
    } row_type;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cmd_init = 1'b0;
    logic        cmd_start = 1'b0;
    logic [1:0]  cmd_mode = 2'h0;
    logic [11:0] cmd_displacement = 12'h0;
    logic        cmd_speed_load = 1'b0;
    logic [1:0]  cmd_speed = 2'h0;
    logic        cmd_pattern_load = 1'b0;
    logic [1:0]  cmd_pattern = 2'h0;
    logic        converter_overflow = 1'b0;
    logic        busy, unblank, attenuate, ramp_rising, conic_active;
    logic [11:0] ramp_value;
    logic [3:0]  seen;
    logic        tog = 1'b0;
    int          errors = 0;
    int          samples_checked = 0;
    int          rises;
    int          rise_log [10];
    row_type     rows [10] = '{'{2'h0, 12'h100, 2'h0, 2'h0, 1'b0, 4'h0},
        '{2'h1, 12'h040, 2'h0, 2'h0, 1'b0, 4'h0}, '{2'h2, 12'h0c0, 2'h0, 2'h0, 1'b0, 4'h8},
        '{2'h2, 12'h010, 2'h0, 2'h0, 1'b0, 4'hc}, '{2'h3, 12'h0c0, 2'h0, 2'h0, 1'b0, 4'ha},
        '{2'h2, 12'h100, 2'h1, 2'h0, 1'b0, 4'h9}, '{2'h2, 12'h100, 2'h2, 2'h0, 1'b0, 4'h9},
        '{2'h2, 12'h100, 2'h3, 2'h0, 1'b0, 4'h9}, '{2'h2, 12'h100, 2'h1, 2'h1, 1'b0, 4'h9},
        '{2'h2, 12'h0c0, 2'h0, 2'h0, 1'b1, 4'h0}};
    vector_ramp_if link_if ();
    vector_controller u_vector_controller (.clk(clk), .sys_rst(sys_rst), .cmd_init(cmd_init),
        .cmd_start(cmd_start), .cmd_mode(cmd_mode), .cmd_displacement(cmd_displacement),
        .cmd_speed_load(cmd_speed_load), .cmd_speed(cmd_speed), .busy(busy),
        .cmd_pattern_load(cmd_pattern_load), .cmd_pattern(cmd_pattern), .link(link_if));
    vector_ramp_gen u_vector_ramp_gen (.clk(clk), .sys_rst(sys_rst), .unblank(unblank),
        .converter_overflow(converter_overflow), .attenuate(attenuate), .link(link_if),
        .ramp_rising(ramp_rising), .conic_active(conic_active), .ramp_value(ramp_value));
    vector_ramp_chk u_chk (.clk(clk), .sys_rst(sys_rst),
        .mode_select_bit2(link_if.mode_select_bit2), .displacement(link_if.displacement),
        .vector_start_strobe_n(link_if.vector_start_strobe_n),
        .conic_start_strobe_n(link_if.conic_start_strobe_n),
        .vector_init_pulse_n(link_if.vector_init_pulse_n),
        .pattern_code_strobe_n(link_if.pattern_code_strobe_n),
        .ramp_at_limit_a_n(link_if.ramp_at_limit_a_n),
        .ramp_at_limit_b_n(link_if.ramp_at_limit_b_n));
    // The clock toggles every half period of 2 ns.
    always #2 clk = ~clk;
    // Compares one observed value with its expected value.
    task automatic check(input logic [3:0] got, input logic [3:0] want);
        samples_checked++;
        if (got !== want) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, want);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("%0d values checked, %0d mismatches", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Pulses a start command; every call flips the expected direction, accepted or not.
    task automatic start_op(input logic [1:0] m, input logic [11:0] d);
        cmd_mode = m;
        cmd_displacement = d;
        cmd_start = 1'b1;
        @(negedge clk);
        cmd_start = 1'b0;
        tog = ~tog;
    endtask
    // Waits for busy to drop, recording what the beam did; a hang ends the run.
    task automatic wait_idle();
        int   n;
        logic last;
        n = 0;
        last = 1'b0;
        seen = 4'h0;
        rises = 0;
        while ((busy === 1'b1 || n < 4) && n < 20000) begin
            @(negedge clk);
            seen = seen | {unblank, attenuate, conic_active, 1'b0};
            if (unblank === 1'b1 && last !== 1'b1) rises++;
            last = unblank;
            n++;
        end
        seen[0] = rises > 1;
        if (n == 20000) begin
            errors++;
            wrap_up();
        end
    endtask
    // Loads speed and pattern codes, then runs one operation to the end.
    task automatic run(input row_type r);
        converter_overflow = r.ovf;
        cmd_speed = r.spd;
        cmd_speed_load = 1'b1;
        @(negedge clk);
        cmd_speed_load = 1'b0;
        cmd_pattern = r.pat;
        cmd_pattern_load = 1'b1;
        @(negedge clk);
        cmd_pattern_load = 1'b0;
        repeat (4) @(negedge clk);  // Lets the overflow synchroniser settle.
        start_op(r.mode, r.disp);
        wait_idle();
    endtask
    // Main sequence: reset, table of operations, then the awkward cases.
    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        check({ramp_rising, unblank, attenuate, link_if.ramp_at_limit_b_n}, 4'h0);
        foreach (rows[i]) begin
            run(rows[i]);
            rise_log[i] = rises;
            check(seen, rows[i].want);
            check({3'h0, ramp_rising}, {3'h0, tog});
            check({3'h0, ramp_value == (tog ? 12'hfff : 12'h000)}, 4'h1);
            $display("row %0d done", i);
        end
        converter_overflow = 1'b0;
        check({3'h0, rise_log[8] < rise_log[5]}, 4'h1);
        start_op(2'h2, 12'h010);
        repeat (20) @(negedge clk);
        start_op(2'h2, 12'h010);
        tog = ~tog;  // The second start arrives while busy and is dropped.
        wait_idle();
        repeat (20) @(negedge clk);
        check({busy, 2'h0, ramp_rising}, {1'b0, 2'h0, tog});
        cmd_init = 1'b1;
        @(negedge clk);
        cmd_init = 1'b0;
        repeat (4) @(negedge clk);
        check({3'h0, ramp_rising}, 4'h0);
        tog = 1'b0;
        run(rows[2]);
        check({3'h0, ramp_rising}, {3'h0, tog});
        $display("busy start and init test done");
        start_op(2'h2, 12'h100);
        repeat (50) @(negedge clk);
        sys_rst = 1'b1;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        check({busy, unblank, ramp_rising, link_if.ramp_at_limit_b_n}, 4'h0);
        $display("mid-run reset test done");
        wrap_up();
    end
endmodule
`default_nettype wire
